// ---- verilog/phyirq_pkg.sv ----
// Purpose: Shared constants and types for the PHY interrupt and downgrade registers.
// Assumes: 16-bit management registers addressed by a 5-bit register number.
// Notes: Every offset, field position, reset value and timing count lives here.
package phyirq_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int REG_W = 16; // Width of every management register.
    localparam int ADDR_W = 5; // Width of the register number.
    localparam logic [4:0] OFF_IRQ_ENABLE = 5'h12; // Interrupt enable register.
    localparam logic [4:0] OFF_IRQ_STATUS = 5'h13; // Latched interrupt status.
    localparam logic [4:0] OFF_DG_CONFIG = 5'h14; // Speed downgrade configuration.
    localparam logic [4:0] OFF_RX_ERRORS = 5'h15; // Receive error counter.
    localparam logic [4:0] OFF_EXT_POINTER = 5'h1E; // Extended register pointer.
    localparam logic [4:0] OFF_EXT_WINDOW = 5'h1F; // Extended register data window.

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_AN_ERROR = 15; // Auto-negotiation error.
    localparam int BIT_SPEED_CHANGE = 14; // Speed change.
    localparam int BIT_DUPLEX_CHANGE = 13; // Duplex change.
    localparam int BIT_PAGE_RECEIVED = 12; // Page received.
    localparam int BIT_LINK_FAIL = 11; // Link fail.
    localparam int BIT_LINK_COMPLETE = 10; // Link complete.
    localparam int BIT_WAKE_ON_LAN = 6; // Wake-on-LAN.
    localparam int BIT_WS_DOWNGRADE = 5; // Wirespeed downgrade.
    localparam int BIT_POLARITY = 1; // Polarity change.
    localparam int BIT_JABBER = 0; // Jabber.
    localparam int BIT_MDIO_LATCH = 11; // Latch read value during a read.
    localparam int BIT_DG_ENABLE = 5; // Automatic speed downgrade enable.
    localparam int POS_ATTEMPTS = 2; // Low bit of the attempt count field.
    localparam int ATTEMPTS_W = 3; // Width of the attempt count field.
    localparam int BIT_TIMER_BYPASS = 1; // Link stability timer bypass.
    localparam logic [3:0] ATTEMPT_EXTRA = 4'h2; // Attempts beyond the field value.

    // ************************************************************
    // Reset values and masks
    // ************************************************************
    localparam logic [15:0] IRQ_ENABLE_RST = 16'h0000; // All interrupts off.
    localparam logic [15:0] IRQ_STATUS_RST = 16'h0000; // No events pending.
    localparam logic [15:0] IRQ_STATUS_MASK = 16'hFC63; // Bits that can ever be set.
    localparam logic [15:0] DG_CONFIG_RST = 16'h082C; // Latch on, downgrade on, 3.
    localparam logic [15:0] DG_CONFIG_WMASK = 16'h0FFE; // Writable configuration bits.
    localparam logic [15:0] RX_ERRORS_RST = 16'h0000; // Counter starts empty.
    localparam logic [15:0] EXT_POINTER_RST = 16'h0000; // Pointer starts at zero.
    localparam logic [15:0] EXT_WINDOW_RST = 16'h0000; // Window write data at reset.

    // ************************************************************
    // Timing
    // ************************************************************
    localparam real CLK_FREQ_HZ = 10.0e6; // Block clock rate.
    localparam real STABLE_TIME_S = 2.5; // Least link life that counts as stable.
    localparam int STABLE_CYCLES = int'(STABLE_TIME_S * CLK_FREQ_HZ); // Whole cycles.

    // Event pulses from the PHY, one cycle each.
    typedef struct packed {
        logic autoneg_error;
        logic speed_change;
        logic duplex_change;
        logic page_received;
        logic link_fail;
        logic link_complete;
        logic wake_on_lan;
        logic polarity_change;
        logic jabber;
    } phyirq_events_type;

    // Places the event pulses at their status bit positions.
    function automatic logic [15:0] event_word(input phyirq_events_type ev,
                                               input logic ws_dg);
        logic [15:0] w;
        w = 16'h0000;
        w[BIT_AN_ERROR] = ev.autoneg_error;
        w[BIT_SPEED_CHANGE] = ev.speed_change;
        w[BIT_DUPLEX_CHANGE] = ev.duplex_change;
        w[BIT_PAGE_RECEIVED] = ev.page_received;
        w[BIT_LINK_FAIL] = ev.link_fail;
        w[BIT_LINK_COMPLETE] = ev.link_complete;
        w[BIT_WAKE_ON_LAN] = ev.wake_on_lan;
        w[BIT_WS_DOWNGRADE] = ws_dg;
        w[BIT_POLARITY] = ev.polarity_change;
        w[BIT_JABBER] = ev.jabber;
        return w;
    endfunction : event_word

endpackage : phyirq_pkg

// ---- verilog/phyirq_sat_counter.sv ----
// Purpose: Saturating event counter with clear.
// Assumes: Increment and clear come from logic on the same clock.
// Notes: A count arriving with a clear is kept, so no error goes missing.
`timescale 1ns/100ps
module phyirq_sat_counter #(
    parameter int WIDTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic inc_in,
    input wire logic clear_in,
    output logic [WIDTH-1:0] count_out
);

    // Count, clear, and hold at the top value instead of wrapping.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_out <= '0;
        end else if (clear_in) begin
            count_out <= {{(WIDTH-1){1'b0}}, inc_in};
        end else if (inc_in && (count_out != {WIDTH{1'b1}})) begin
            count_out <= count_out + 1'b1;
        end
    end

endmodule : phyirq_sat_counter

// ---- verilog/phyirq_downgrade.sv ----
// Purpose: Automatic speed downgrade state machine.
// Assumes: Attempt failures and link level come from logic on this clock.
// Notes: Enable and attempt count are sampled only at hardware or software reset.
`timescale 1ns/100ps
module phyirq_downgrade #(
    parameter int STABLE_CYCLES = phyirq_pkg::STABLE_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sw_reset_in,
    input wire logic cfg_enable_in,
    input wire logic [2:0] cfg_attempts_in,
    input wire logic bypass_in,
    input wire logic an_fail_in,
    input wire logic link_up_in,
    output logic downgrade_out,
    output logic event_out
);

    typedef enum logic [1:0] {DG_TRYING, DG_LINKED, DG_DONE} phyirq_dg_state_type;

    phyirq_dg_state_type state_q; // Downgrade progress.
    logic enable_q; // Enable in force since the last reset.
    logic [3:0] limit_q; // Failures that trigger a downgrade.
    logic [3:0] tries_q; // Failures counted so far.
    logic [31:0] timer_q; // Cycles the current link has lasted.
    logic stable_w; // The link has now lasted long enough.
    logic fail_w; // This cycle counts as a failed attempt.

    assign stable_w = (timer_q >= 32'(STABLE_CYCLES - 1));

    // A short-lived link is a failure unless the timer is bypassed.
    always_comb begin
        fail_w = 1'b0;
        if (state_q == DG_TRYING) begin
            fail_w = an_fail_in;
        end else if (state_q == DG_LINKED) begin
            fail_w = !link_up_in && !bypass_in && !stable_w;
        end
    end

    // New enable and attempt settings are taken only at a reset, so a change mid-run cannot
    // confuse a count already in progress.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            enable_q <= phyirq_pkg::DG_CONFIG_RST[phyirq_pkg::BIT_DG_ENABLE];
            limit_q <= {1'b0, phyirq_pkg::DG_CONFIG_RST[4:2]} + phyirq_pkg::ATTEMPT_EXTRA;
        end else if (sw_reset_in) begin
            enable_q <= cfg_enable_in;
            limit_q <= {1'b0, cfg_attempts_in} + phyirq_pkg::ATTEMPT_EXTRA;
        end
    end

    // Tracks attempts and decides the downgrade.
    always_ff @(posedge clk_in) begin
        event_out <= 1'b0;
        if (rst_in || sw_reset_in) begin
            state_q <= DG_TRYING;
            tries_q <= 4'h0;
            timer_q <= 32'h0000_0000;
            downgrade_out <= 1'b0;
        end else begin
            unique case (state_q)
                DG_TRYING: begin
                    timer_q <= 32'h0000_0000;
                    if (link_up_in) begin
                        state_q <= DG_LINKED;
                    end
                end
                DG_LINKED: begin
                    if (!link_up_in) begin
                        state_q <= DG_TRYING;
                    end else if (!stable_w) begin
                        timer_q <= timer_q + 32'h0000_0001;
                    end else begin
                        tries_q <= 4'h0; // A stable link restarts the count.
                    end
                end
                DG_DONE: begin
                    downgrade_out <= 1'b1;
                end
            endcase
            if (fail_w) begin
                tries_q <= tries_q + 4'h1;
                if (enable_q && (tries_q + 4'h1 >= limit_q)) begin
                    state_q <= DG_DONE;
                    event_out <= 1'b1;
                    downgrade_out <= 1'b1;
                end
            end
        end
    end

endmodule : phyirq_downgrade

// ---- verilog/phyirq_regs.sv ----
// Purpose: Interrupt, speed downgrade, error count and extended window registers.
// Assumes: Management reads and writes arrive as one-cycle strobes from the
//          MDIO frame engine on this clock; event pulses come from PHY logic.
// Notes: The extended bank answers combinationally on the pointer output.
`timescale 1ns/100ps
module phyirq_regs #(
    parameter int STABLE_CYCLES = phyirq_pkg::STABLE_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sw_reset_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    input wire phyirq_pkg::phyirq_events_type events_in,
    input wire logic an_fail_in,
    input wire logic link_up_in,
    input wire logic rx_error_in,
    output logic [15:0] ext_addr_out,
    output logic [15:0] ext_wdata_out,
    output logic ext_wr_out,
    output logic ext_rd_out,
    input wire logic [15:0] ext_rdata_in,
    output logic irq_out,
    output logic downgrade_out
);

    // ************************************************************
    // Storage and decode
    // ************************************************************
    logic [15:0] enable_q; // Interrupt enables, every bit writable.
    logic [15:0] status_q; // Latched event flags.
    logic [15:0] status_d; // Next value of the flags.
    logic [15:0] config_q; // Downgrade configuration.
    logic [15:0] rx_count_w; // Receive error count.
    logic [15:0] set_w; // Events arriving this cycle.
    logic ws_event_w; // Downgrade decision pulse.
    logic rd_status_w; // Read of the status register.
    logic rd_count_w; // Read of the error counter.

    assign rd_status_w = reg_rd_in && (reg_addr_in == phyirq_pkg::OFF_IRQ_STATUS);
    assign rd_count_w = reg_rd_in && (reg_addr_in == phyirq_pkg::OFF_RX_ERRORS);
    assign set_w = phyirq_pkg::event_word(events_in, ws_event_w);

    // Returns the register value for a register number; unknown numbers read zero.
    function automatic logic [15:0] read_word(input logic [4:0] addr);
        logic [15:0] v;
        v = 16'h0000;
        unique case (addr)
            phyirq_pkg::OFF_IRQ_ENABLE: v = enable_q;
            phyirq_pkg::OFF_IRQ_STATUS: v = status_q;
            phyirq_pkg::OFF_DG_CONFIG: v = config_q;
            phyirq_pkg::OFF_RX_ERRORS: v = rx_count_w;
            phyirq_pkg::OFF_EXT_POINTER: v = ext_addr_out;
            phyirq_pkg::OFF_EXT_WINDOW: v = ext_rdata_in;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction : read_word

    // ************************************************************
    // Interrupt enables
    // ************************************************************
    // Every bit is plain read-write; bit 15 of the top field gates the
    // auto-negotiation error flag and bit 14 gates the speed change flag.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            enable_q <= phyirq_pkg::IRQ_ENABLE_RST;
        end else if (reg_wr_in && (reg_addr_in == phyirq_pkg::OFF_IRQ_ENABLE)) begin
            enable_q <= reg_wdata_in;
        end
    end

    // ************************************************************
    // Interrupt status
    // ************************************************************
    // A new event wins over the read that clears, so an event landing in
    // the cycle of the read is reported at the next read instead of lost.
    always_comb begin
        status_d = status_q;
        if (rd_status_w) begin
            status_d = 16'h0000;
        end
        status_d = (status_d | set_w) & phyirq_pkg::IRQ_STATUS_MASK;
    end

    // Flags hold until read.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            status_q <= phyirq_pkg::IRQ_STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    // The interrupt is a registered level one cycle behind the flags.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(status_q & enable_q);
        end
    end

    // ************************************************************
    // Downgrade configuration and state machine
    // ************************************************************
    // Reserved bits 15:12 and 0 never take a write and read zero.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            config_q <= phyirq_pkg::DG_CONFIG_RST;
        end else if (reg_wr_in && (reg_addr_in == phyirq_pkg::OFF_DG_CONFIG)) begin
            config_q <= reg_wdata_in & phyirq_pkg::DG_CONFIG_WMASK;
        end
    end

    // Enable and attempt count are only sampled by the machine at a reset.
    phyirq_downgrade #(
        .STABLE_CYCLES(STABLE_CYCLES)
    ) u_downgrade (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .sw_reset_in(sw_reset_in),
        .cfg_enable_in(config_q[phyirq_pkg::BIT_DG_ENABLE]),
        .cfg_attempts_in(config_q[phyirq_pkg::POS_ATTEMPTS +: phyirq_pkg::ATTEMPTS_W]),
        .bypass_in(config_q[phyirq_pkg::BIT_TIMER_BYPASS]),
        .an_fail_in(an_fail_in),
        .link_up_in(link_up_in),
        .downgrade_out(downgrade_out),
        .event_out(ws_event_w)
    );

    // ************************************************************
    // Receive error counter
    // ************************************************************
    // A read clears the count; an error in the read cycle starts the new count.
    phyirq_sat_counter #(
        .WIDTH(phyirq_pkg::REG_W)
    ) u_rx_errors (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .inc_in(rx_error_in),
        .clear_in(rd_count_w),
        .count_out(rx_count_w)
    );

    // ************************************************************
    // Extended register window
    // ************************************************************
    // The pointer drives the extended bank directly and reads back as written.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ext_addr_out <= phyirq_pkg::EXT_POINTER_RST;
        end else if (reg_wr_in && (reg_addr_in == phyirq_pkg::OFF_EXT_POINTER)) begin
            ext_addr_out <= reg_wdata_in;
        end
    end

    // Writes and reads of the window become one-cycle strobes to the bank.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ext_wdata_out <= phyirq_pkg::EXT_WINDOW_RST;
            ext_wr_out <= 1'b0;
            ext_rd_out <= 1'b0;
        end else begin
            ext_wr_out <= reg_wr_in && (reg_addr_in == phyirq_pkg::OFF_EXT_WINDOW);
            ext_rd_out <= reg_rd_in && (reg_addr_in == phyirq_pkg::OFF_EXT_WINDOW);
            if (reg_wr_in && (reg_addr_in == phyirq_pkg::OFF_EXT_WINDOW)) begin
                ext_wdata_out <= reg_wdata_in;
            end
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    // With latching on, the value is held from the read strobe so that a
    // slow serial shift-out sees one consistent word. With it off the
    // output tracks the addressed register every cycle.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in || !config_q[phyirq_pkg::BIT_MDIO_LATCH]) begin
            reg_rdata_out <= read_word(reg_addr_in);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    a_status_hold: assert property (!rd_status_w |=>
        ((status_q & $past(status_q)) == $past(status_q)))
        else $error("status flag dropped without a read");

    a_status_clear: assert property ((rd_status_w && set_w == 16'h0000) |=>
        (status_q == 16'h0000))
        else $error("status not cleared by read");

    a_set_wins: assert property ((rd_status_w && set_w != 16'h0000) |=>
        (status_q == $past(set_w)))
        else $error("event lost at read clear");

    a_reserved_zero: assert property ((status_q & 16'h039C) == 16'h0000)
        else $error("reserved status bit set");

    a_irq_follow: assert property (((set_w & enable_q) != 16'h0000 && !rd_status_w
        && !reg_wr_in) |=> ##1 irq_out)
        else $error("enabled event raised no interrupt");

    a_irq_quiet: assert property ((status_q == 16'h0000 && !reg_wr_in && set_w == 16'h0000)
        |=> !irq_out)
        else $error("interrupt without an enabled flag");

    a_enable_write: assert property ((reg_wr_in && reg_addr_in == 5'h12) |=>
        (enable_q == $past(reg_wdata_in)))
        else $error("enable write not stored");

    a_count_sat: assert property ((rx_count_w == 16'hFFFF && !rd_count_w) |=>
        (rx_count_w == 16'hFFFF))
        else $error("error count wrapped");

    a_count_clear: assert property ((rd_count_w && !rx_error_in) |=>
        (rx_count_w == 16'h0000))
        else $error("error count not cleared by read");

    a_latch_hold: assert property ((config_q[11] && !reg_rd_in) |=>
        $stable(reg_rdata_out))
        else $error("latched read data changed");

    a_ptr_write: assert property ((reg_wr_in && reg_addr_in == 5'h1E) |=>
        (ext_addr_out == $past(reg_wdata_in)) ##1 (ext_addr_out == $past(reg_wdata_in, 2)
        || $past(reg_wr_in)))
        else $error("pointer write lost");

    a_window_write: assert property ((reg_wr_in && reg_addr_in == 5'h1F) |=>
        (ext_wr_out && ext_wdata_out == $past(reg_wdata_in)))
        else $error("window write not forwarded");

    c_status_read: cover property (rd_status_w && status_q != 16'h0000);
    c_irq_rise: cover property (!irq_out ##1 irq_out);
    c_count_full: cover property (rx_count_w == 16'hFFFF && rx_error_in);
    c_downgrade: cover property (!downgrade_out ##1 downgrade_out);

endmodule : phyirq_regs

// ---- testbench/phyirq_ext_bank.sv ----
// Purpose: Extended register bank that answers behind the data window.
// Assumes: Pointer and write strobe come from the block on the same clock.
// Notes: Only the low four pointer bits pick a word, to keep the model small.
`timescale 1ns/100ps
module phyirq_ext_bank (
    input wire logic clk_in,
    input wire logic [15:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    output logic [15:0] rdata_out
);
    // Words start cleared, as the extended registers do after reset.
    logic [15:0] mem_q [16];
    initial begin
        foreach (mem_q[i]) mem_q[i] = 16'h0000;
    end
    // A window write lands in the word that the pointer selects.
    always @(posedge clk_in) begin
        if (wr_in) begin
            mem_q[addr_in[3:0]] <= wdata_in;
        end
    end
    // Reads answer at once, since the block samples on its read edge.
    assign rdata_out = mem_q[addr_in[3:0]];
endmodule : phyirq_ext_bank

// ---- testbench/test_phyirq_regs.sv ----
// Purpose: Self-checking bench for the interrupt and downgrade registers.
// Assumes: Strobes are one-cycle pulses given just after a rising edge.
// Notes: The stability count is cut to 20 cycles to keep the run short.
`timescale 1ns/100ps
module test_phyirq_regs;
    // ************************************************************
    // Signals, model and design
    // ************************************************************
    logic clk_in = 1'b0, rst_in = 1'b1, sw_reset_in = 1'b0;
    logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, an_fail_in = 1'b0;
    logic link_up_in = 1'b0, rx_error_in = 1'b0;
    logic [4:0] reg_addr_in = 5'h00;
    logic [15:0] reg_wdata_in = 16'h0000;
    phyirq_pkg::phyirq_events_type events_in = '0;
    logic [15:0] reg_rdata_out, ext_addr_out, ext_wdata_out, ext_rdata_in;
    logic ext_wr_out, ext_rd_out, irq_out, downgrade_out;
    int n_errors = 0;
    int n_tests = 0;
    always #50 clk_in = ~clk_in;
    phyirq_ext_bank i_bank (.clk_in(clk_in), .addr_in(ext_addr_out),
        .wdata_in(ext_wdata_out), .wr_in(ext_wr_out), .rdata_out(ext_rdata_in));
    phyirq_regs #(.STABLE_CYCLES(20)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
        .sw_reset_in(sw_reset_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .events_in(events_in), .an_fail_in(an_fail_in), .link_up_in(link_up_in),
        .rx_error_in(rx_error_in), .ext_addr_out(ext_addr_out),
        .ext_wdata_out(ext_wdata_out), .ext_wr_out(ext_wr_out), .ext_rd_out(ext_rd_out),
        .ext_rdata_in(ext_rdata_in), .irq_out(irq_out), .downgrade_out(downgrade_out));
    // ************************************************************
    // Access tasks
    // ************************************************************
    // Compares with case equality so an unknown never passes.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    // Read data is registered, so it is sampled just after the next edge.
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(reg_rdata_out, exp);
    endtask : rd
    // Failed attempts, then a short settle before the level is looked at.
    task automatic fail(input int n, input logic exp);
        repeat (n) begin
            @(posedge clk_in);
            an_fail_in <= 1'b1;
            @(posedge clk_in);
            an_fail_in <= 1'b0;
        end
        repeat (3) @(posedge clk_in);
        #1 chk({15'h0000, downgrade_out}, {15'h0000, exp});
    endtask : fail
    // Writes the settings and restarts the downgrade machine with them.
    task automatic restart(input logic [15:0] cfg);
        wr(5'h14, cfg);
        @(posedge clk_in);
        sw_reset_in <= 1'b1;
        @(posedge clk_in);
        sw_reset_in <= 1'b0;
    endtask : restart
    task automatic final_report();
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    // ************************************************************
    // Tests
    // ************************************************************
    // Cuts a hang short; the tests need about 66000 cycles.
    initial begin
        #9000000;
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report();
    end
    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(5'h12, 16'h0000);
        rd(5'h13, 16'h0000);
        rd(5'h14, 16'h082C);
        rd(5'h15, 16'h0000);
        rd(5'h00, 16'h0000);
        wr(5'h12, 16'hFFFF);
        rd(5'h12, 16'hFFFF);
        wr(5'h13, 16'hFFFF);
        rd(5'h13, 16'h0000);
        @(posedge clk_in);
        events_in <= '1;
        @(posedge clk_in);
        events_in <= '0;
        repeat (2) @(posedge clk_in);
        #1 chk({15'h0000, irq_out}, 16'h0001);
        rd(5'h13, 16'hFC43);
        rd(5'h13, 16'h0000);
        repeat (2) @(posedge clk_in);
        #1 chk({15'h0000, irq_out}, 16'h0000);
        wr(5'h14, 16'hFFFF);
        rd(5'h14, 16'h0FFE);
        fail(4, 1'b0);
        fail(1, 1'b1);
        rd(5'h13, 16'h0020);
        restart(16'h0802);
        fail(3, 1'b0);
        restart(16'h0822);
        fail(1, 1'b0);
        fail(1, 1'b1);
        restart(16'h0820);
        link_up_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        link_up_in <= 1'b0;
        fail(1, 1'b1);
        wr(5'h1E, 16'h0003);
        wr(5'h1F, 16'h1234);
        rd(5'h1F, 16'h1234);
        rd(5'h1E, 16'h0003);
        rx_error_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rx_error_in <= 1'b0;
        rd(5'h15, 16'h0003);
        rd(5'h15, 16'h0000);
        rx_error_in <= 1'b1;
        repeat (65540) @(posedge clk_in);
        rx_error_in <= 1'b0;
        rd(5'h15, 16'hFFFF);
        final_report();
    end
endmodule : test_phyirq_regs
